// >>> hw/ist_pkg.sv
// Behaviour
// - in IEC-958 mode each sub-frame takes exactly 64 unit intervals, one descriptor each
// - transparent mode shifts each 32-bit word out in 32 unit intervals, configured order
// - only preamble and parity are generated; every other bit is copied from the descriptor
// - data cell: first state inverts previous state, second flips for one, holds for zero
// - preambles are sent as deliberate coding violations
// - each cell state lasts one synthesizer cycle, so a bit cell is two cycles
// - every preamble opens with a rising edge, relying on even parity
// - parity cell makes cells 4 to 31 hold an even count of ones, bi-phase coded
// - descriptor bits 30 to 4 give the sub-frame slot values, then cell coded
// - low four bits pick preamble: 0 block-start, 1 left, 2 right, others reserved
// - byte-order one: word built from a+3 down to a, a+3 most significant
// - byte-order zero: word built from a up to a+3, a most significant
// - two buffers alternate without gap; a finished one is flagged for refill
// - transparent mode sends all 32 bits verbatim: no coding, parity or preamble
// - transmission begins only when software sets transmit_on after programming buffers
package ist_pkg;
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_BASE1 = 8'h04;
  localparam logic [7:0] ADDR_BASE2 = 8'h08;
  localparam logic [7:0] ADDR_SIZE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTL_ON = 0;
  localparam int CTL_TRANSP = 1;
  localparam int CTL_MSB = 2;
  localparam int CTL_LE = 3;
  localparam int CTL_ACK1 = 4;
  localparam int CTL_ACK2 = 5;
  localparam logic [31:0] REG_RST = 32'h0;
  localparam logic [5:0] IEC_LAST = 6'h3f;
  localparam logic [4:0] TR_LAST = 5'h1f;
  localparam logic [5:0] PRE_UIS = 6'h08;
  localparam logic [4:0] PAR_SLOT = 5'h1f;
  localparam logic [3:0] CODE_B = 4'h0;
  localparam logic [3:0] CODE_M = 4'h1;
  localparam logic [3:0] CODE_W = 4'h2;
  localparam logic [7:0] PRE_B = 8'he8;
  localparam logic [7:0] PRE_M = 8'he2;
  localparam logic [7:0] PRE_W = 8'he4;
  localparam logic [31:0] WORD_BYTES = 32'h4;
  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_FULL} ist_fetch_t;
endpackage

// >>> hw/ist_top.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ist_top (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic half_cell_tick_i,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic serial_o
);
  import ist_pkg::*;

  logic transmit_on, transp, msb_first, little_end;
  logic [31:0] base1, base2, size_b;
  logic empty1, empty2;
  logic sel;
  logic [31:0] off;
  ist_fetch_t fstate;
  logic [31:0] next_word;
  logic [31:0] cur;
  logic running;
  logic [5:0] cnt;
  logic next_line;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CTL) || (a == ADDR_BASE1) || (a == ADDR_BASE2) ||
             (a == ADDR_SIZE) || (a == ADDR_STATUS);
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // first unit interval of the preamble is the pattern's top bit
  function automatic logic pre_bit(input logic [3:0] code, input logic [2:0] idx);
    logic [7:0] pat;
    case (code)
      CODE_M: pat = PRE_M;
      CODE_W: pat = PRE_W;
      default: pat = PRE_B; // reserved codes fall back to block-start
    endcase
    pre_bit = pat[3'h7 - idx];
  endfunction

  // apb slave: zero wait states, read data latched in the setup phase
  logic apb_wr, apb_setup, ack1, ack2;
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign apb_setup = psel_i & ~penable_i;
  assign ack1 = apb_wr && paddr_i == ADDR_CTL && pwdata_i[CTL_ACK1];
  assign ack2 = apb_wr && paddr_i == ADDR_CTL && pwdata_i[CTL_ACK2];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transmit_on <= 1'b0;
      transp <= 1'b0;
      msb_first <= 1'b0;
      little_end <= 1'b0;
      base1 <= REG_RST;
      base2 <= REG_RST;
      size_b <= REG_RST;
    end else if (apb_wr) begin
      case (paddr_i)
        ADDR_CTL: begin
          transmit_on <= pwdata_i[CTL_ON];
          transp <= pwdata_i[CTL_TRANSP];
          msb_first <= pwdata_i[CTL_MSB];
          little_end <= pwdata_i[CTL_LE];
        end
        ADDR_BASE1: base1 <= pwdata_i;
        ADDR_BASE2: base2 <= pwdata_i;
        ADDR_SIZE: size_b <= pwdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= REG_RST;
    end else if (apb_setup) begin
      case (paddr_i)
        ADDR_CTL: prdata_o <= {28'h0, little_end, msb_first, transp, transmit_on};
        ADDR_BASE1: prdata_o <= base1;
        ADDR_BASE2: prdata_o <= base2;
        ADDR_SIZE: prdata_o <= size_b;
        ADDR_STATUS: prdata_o <= {28'h0, running, sel, empty2, empty1};
        default: prdata_o <= REG_RST;
      endcase
    end
  end

  // descriptor fetch: one word held ahead of the one on the line
  logic fetched, last_word, take;
  logic [31:0] fetch_addr;
  // a late answer after disable must not set an empty flag
  assign fetched = (fstate == F_WAIT) & mem_ack_i & transmit_on;
  assign last_word = (off + WORD_BYTES) >= size_b;
  assign fetch_addr = (sel ? base2 : base1) + off;
  assign mem_req_o = (fstate == F_WAIT);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fstate <= F_IDLE;
      sel <= 1'b0;
      off <= REG_RST;
      mem_addr_o <= REG_RST;
      next_word <= REG_RST;
    end else if (!transmit_on) begin
      // a pending read is dropped; restart from buffer one
      fstate <= F_IDLE;
      sel <= 1'b0;
      off <= REG_RST;
    end else begin
      case (fstate)
        F_IDLE: begin
          mem_addr_o <= fetch_addr;
          fstate <= F_WAIT;
        end
        F_WAIT: begin
          if (mem_ack_i) begin
            next_word <= little_end ? mem_rdata_i : swap32(mem_rdata_i);
            fstate <= F_FULL;
            if (last_word) begin
              off <= REG_RST;
              sel <= ~sel;
            end else begin
              off <= off + WORD_BYTES;
            end
          end
        end
        F_FULL: begin
          if (take) begin
            fstate <= F_IDLE;
          end
        end
        default: fstate <= F_IDLE;
      endcase
    end
  end

  // set wins over the acknowledge in the same cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      empty1 <= 1'b0;
      empty2 <= 1'b0;
    end else begin
      empty1 <= (empty1 & ~ack1) | (fetched & last_word & ~sel);
      empty2 <= (empty2 & ~ack2) | (fetched & last_word & sel);
    end
  end

  // line sequencer: one unit interval per synthesizer tick
  logic at_last, parity, data_bit, tbit;
  logic [4:0] slot, tidx;
  assign at_last = transp ? (cnt[4:0] == TR_LAST) : (cnt == IEC_LAST);
  assign slot = cnt[5:1];
  // in IEC-958 mode word bit 31 is not sent; slot 31 carries parity instead
  assign parity = ^cur[30:4];
  assign data_bit = (slot == PAR_SLOT) ? parity : cur[slot];
  assign tidx = msb_first ? (TR_LAST - cnt[4:0]) : cnt[4:0];
  assign tbit = cur[tidx];
  assign take = (fstate == F_FULL) && (!running || (half_cell_tick_i && at_last));

  always_comb begin
    if (transp) begin
      next_line = tbit;
    end else if (cnt < PRE_UIS) begin
      next_line = pre_bit(cur[3:0], cnt[2:0]);
    end else if (!cnt[0]) begin
      next_line = ~serial_o;
    end else begin
      next_line = serial_o ^ data_bit;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      running <= 1'b0;
      cnt <= 6'h0;
      cur <= REG_RST;
      serial_o <= 1'b0;
    end else if (!transmit_on) begin
      // disable cuts the line at once, even mid-cell; the receiver sees a torn frame
      running <= 1'b0;
      cnt <= 6'h0;
      serial_o <= 1'b0;
    end else if (!running) begin
      if (take) begin
        cur <= next_word;
        running <= 1'b1;
        cnt <= 6'h0;
      end
    end else if (half_cell_tick_i) begin
      serial_o <= next_line;
      if (at_last) begin
        cnt <= 6'h0;
        // no fresh word in time: the last descriptor is sent again
        if (take) begin
          cur <= next_word;
        end
      end else begin
        cnt <= cnt + 6'h1;
      end
    end
  end

  logic tick_run;
  assign tick_run = half_cell_tick_i & running & transmit_on;

  a_subframe_wrap: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && !transp && cnt == 6'h3f |=> cnt == 6'h0)
    else $error("sub-frame did not close after 64 unit intervals");

  a_word_wrap: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && transp && cnt == 6'h1f |=> cnt == 6'h0)
    else $error("transparent word did not close after 32 intervals");

  a_cell_inverts: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && !transp && cnt >= 6'h08 && !cnt[0] |=> serial_o != $past(serial_o))
    else $error("cell first state did not invert previous state");

  a_data_copied: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && !transp && cnt >= 6'h08 && cnt[0]
    |=> serial_o == ($past(serial_o) ^ $past(data_bit)))
    else $error("cell second state does not match the data bit");

  a_preamble_rise: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && !transp && cnt == 6'h0 |=> serial_o && !$past(serial_o))
    else $error("preamble did not start with a rising edge");

  a_parity_even: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && !transp && cnt == 6'h3f |=> !serial_o)
    else $error("sub-frame did not end low after the parity cell");

  a_verbatim_bits: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && transp |=> serial_o == $past(tbit))
    else $error("transparent bit differs from the memory word");

  a_idle_quiet: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !transmit_on |=> !serial_o && !running ##1 !transmit_on || !serial_o)
    else $error("line or sequencer active while disabled");

  a_byte_order: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    fetched && transmit_on && !little_end |=> next_word == swap32($past(mem_rdata_i)))
    else $error("byte order zero word assembled wrongly");

  a_buffer_swap: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    fetched && transmit_on && last_word && !sel |=> sel && empty1)
    else $error("buffer one finished without switch and flag");

  a_preamble_break: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_run && !transp && cnt == 6'h2 |=> serial_o == $past(serial_o))
    else $error("preamble lacks its coding violation");

  a_fetch_hold: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    mem_req_o && !mem_ack_i && transmit_on |=> mem_req_o && $stable(mem_addr_o))
    else $error("descriptor read dropped or moved before its answer");

  a_fetch_off: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !transmit_on |=> !mem_req_o)
    else $error("descriptor read requested while disabled");

  a_restart_first: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !transmit_on |=> !sel && off == REG_RST)
    else $error("sequencing does not restart at buffer one");

  a_empty_clear: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ack1 && !(fetched && last_word && !sel) |=> !empty1)
    else $error("buffer one flag not cleared by its acknowledge");

  a_line_holds: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    transmit_on && !half_cell_tick_i |=> $stable(serial_o))
    else $error("line changed between unit intervals");

endmodule
`default_nettype wire

// >>> verification/ist_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ist_mem_model (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [3:0] lat_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] words [0:31];
  logic [3:0] cnt;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 4'h0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0;
    end else begin
      mem_ack_o <= 1'b0;
      // data not valid outside the ack cycle, so keep it moving
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        if (cnt >= lat_i) begin
          mem_ack_o <= 1'b1;
          mem_rdata_o <= words[mem_addr_i[6:2]];
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/iec958_serial_transmitter_test.sv
`timescale 1ns/1ps
`default_nettype none
module iec958_serial_transmitter_test;
  import ist_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, tick = 0, tick_q = 0;
  logic cap_on = 0, pready, pslverr, err, mem_req, mem_ack, serial;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q, mem_addr, mem_rdata;
  logic [3:0] lat = 4'h1;
  logic cap[$];
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  ist_top DUT (.ref_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .half_cell_tick_i(tick), .mem_req_o(mem_req),
    .mem_addr_o(mem_addr), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .serial_o(serial));
  ist_mem_model u_mem (.ref_clk_i(clk), .arst_n_i(rst_n), .mem_req_i(mem_req),
    .mem_addr_i(mem_addr), .lat_i(lat), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
  always @(posedge clk) tick_q <= tick;
  always @(negedge clk) if (tick_q && cap_on) cap.push_back(serial);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [63:0] iec(input logic [31:0] d);
    logic [63:0] v;
    logic lv;
    logic b;
    v = 64'h0;
    case (d[3:0])
      CODE_M: v[63:56] = PRE_M;
      CODE_W: v[63:56] = PRE_W;
      default: v[63:56] = PRE_B;
    endcase
    lv = v[56];
    for (int s = 4; s < 32; s++) begin
      b = (s == 31) ? ^d[30:4] : d[s];
      v[63-2*s] = ~lv;
      v[62-2*s] = ~lv ^ b;
      lv = v[62-2*s];
    end
    return v;
  endfunction
  // ticks only after the first word is in, so capture starts on a word boundary
  task automatic run(input logic [3:0] ctl, input int n, input logic [3:0] l);
    logic [31:0] d;
    logic [31:0] r;
    logic [63:0] v;
    int w;
    w = ctl[1] ? 32 : 64;
    lat <= l;
    cap.delete();
    apb(1'b1, ADDR_CTL, {28'h0, ctl});
    for (int k = 0; k < 200 && mem_ack !== 1'b1; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    tick <= 1'b1;
    cap_on <= 1'b1;
    while (cap.size() < n * w) @(posedge clk);
    tick <= 1'b0;
    cap_on <= 1'b0;
    apb(1'b1, ADDR_CTL, 32'h0);
    repeat (3) @(posedge clk);
    chk("idle line", serial, 64'h0);
    for (int k = 0; k < n; k++) begin
      d = u_mem.words[k % 32];
      if (!ctl[3]) d = {d[7:0], d[15:8], d[23:16], d[31:24]};
      v = 64'h0;
      for (int i = 0; i < w; i++) v[w-1-i] = cap[k*w+i];
      r = {<<{d}};
      if (ctl[1]) chk("raw word", v, {32'h0, ctl[2] ? d : r});
      else chk("sub-frame", v, iec(d));
    end
  endtask
  initial begin
    // block-start word first, then right and left sub-frames in turn
    for (int i = 0; i < 32; i++) begin
      u_mem.words[i] = ((i * 32'h0f1e2d3b) ^ 32'h55aa3c96) & 32'h7fffff70;
      u_mem.words[i][3:0] = (i == 0) ? CODE_B : ((i % 2) ? CODE_W : CODE_M);
    end
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_CTL, 32'h0);
    chk("ctl reset", q, REG_RST);
    apb(1'b1, ADDR_BASE1, 32'h0);
    apb(1'b1, ADDR_BASE2, 32'h40);
    apb(1'b1, ADDR_SIZE, 32'h40);
    apb(1'b0, ADDR_BASE2, 32'h0);
    chk("base2", q, 64'h40);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", err, 64'h1);
    chk("unmapped data", q, 64'h0);
    repeat (20) @(posedge clk);
    chk("fetch before on", mem_req, 64'h0);
    chk("line before on", serial, 64'h0);
    run(4'h9, 34, 4'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("both empty", q[1:0], 64'h3);
    apb(1'b1, ADDR_CTL, 32'h10);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ack one", q[1:0], 64'h2);
    apb(1'b1, ADDR_CTL, 32'h20);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ack two", q[1:0], 64'h0);
    run(4'h1, 8, 4'h9);
    run(4'hb, 6, 4'h3);
    run(4'hf, 6, 4'h3);
    test_done();
  end
endmodule
`default_nettype wire
